/* File: core/occ_consts.vh */
// Constants for the output compare channel
`ifndef OCC_CONSTS_VH
`define OCC_CONSTS_VH
`define OCC_ADDR_W         3
`define OCC_OFF_CTRL       3'h0
`define OCC_OFF_PRIMARY    3'h1
`define OCC_OFF_SECONDARY  3'h2
`define OCC_OFF_STATUS     3'h3
`define OCC_OFF_MASK       3'h4
`define OCC_CTRL_WMASK     16'h200f
`define OCC_CTRL_RESET     16'h0000
`define OCC_BIT_IDLE       13
`define OCC_BIT_FAULT      4
`define OCC_BIT_TSEL       3
`define OCC_MODE_HI        2
`define OCC_MODE_OFF       3'h0
`define OCC_MODE_RISE      3'h1
`define OCC_MODE_FALL      3'h2
`define OCC_MODE_TOGGLE    3'h3
`define OCC_MODE_SINGLE    3'h4
`define OCC_MODE_CONT      3'h5
`define OCC_MODE_PWM       3'h6
`define OCC_MODE_PWMF      3'h7
`define OCC_IRQ_W          2
`define OCC_IRQ_MATCH      0
`define OCC_IRQ_FAULT      1
`endif

/* File: core/occ_channel.v */
// Output compare channel with Avalon-MM register slave
`timescale 1ns/10ps
`include "occ_consts.vh"

// Function
// - Idle-stop set: channel halts while the processor idles.
// - Idle-stop clear: channel keeps running while the processor idles.
// - Fault flag set by hardware on PWM fault, read-only, hardware-cleared.
// - Fault flag used only in PWM-with-fault mode; otherwise stays clear.
// - Timer select one: count comes from second time base.
// - Timer select zero: count comes from first time base.
// - Mode 111: PWM output with fault input monitored.
// - Mode 110: PWM output, fault input ignored.
// - Mode 101: start low, then continuous pulses each timer period.
// - Mode 100: start low, then exactly one pulse.
// - Mode 011: each compare match toggles the output.
// - Mode 010: start high, match forces output low.
// - Mode 001: start low, match forces output high.
// - Mode 000: channel disabled, no events or output activity.
// - Unimplemented control bits read zero, writes ignored.
module occ_channel (
    input  wire        sys_clk,
    input  wire        rstn,
    input  wire [2:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire [15:0] first_time_base,
    input  wire [15:0] second_time_base,
    input  wire        cpu_idle,
    input  wire        pwm_fault_in,
    output reg         compare_output_pin,
    output reg         irq
);

    ////////////////////////////////////////////////////////////////////////////
    reg  [15:0] ctrl_ff;
    reg  [15:0] primary_ff;
    reg  [15:0] secondary_ff;
    reg  [1:0]  status_ff;
    reg  [1:0]  mask_ff;
    reg         fault_ff;
    reg         done_ff;
    reg         fsync1_ff;
    reg         fsync2_ff;
    reg         isync1_ff;
    reg         isync2_ff;
    reg         ack_ff;
    reg         mode_wr_ff;
    reg  [15:0] nxt_ctrl;
    reg  [15:0] nxt_primary;
    reg  [15:0] nxt_secondary;
    reg  [1:0]  nxt_status;
    reg  [1:0]  nxt_mask;
    reg         nxt_out;
    reg         nxt_fault;
    reg         nxt_done;
    reg  [31:0] nxt_rdata;
    reg  [1:0]  ev;

    wire [2:0]  mode      = ctrl_ff[`OCC_MODE_HI:0];
    wire        tsel      = ctrl_ff[`OCC_BIT_TSEL];
    // Second time base when select is one, first otherwise
    wire [15:0] count     = tsel ? second_time_base : first_time_base;
    // Halt only when idle-stop is set and processor is idle
    wire        halted    = ctrl_ff[`OCC_BIT_IDLE] & isync2_ff;
    wire        run       = (mode != `OCC_MODE_OFF) & ~halted;
    wire        match_a   = run & (count == primary_ff);
    wire        match_b   = run & (count == secondary_ff);
    wire        period_st = run & (count == 16'h0000);
    wire        is_pwm    = (mode == `OCC_MODE_PWM) | (mode == `OCC_MODE_PWMF);
    // Single cycle answer: one wait cycle then ack
    wire        access    = (avs_read | avs_write) & ~ack_ff;
    wire        wr        = avs_write & ack_ff;
    wire [15:0] wdata     = avs_writedata[15:0];
    wire [15:0] bmask     = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire        ctrl_wr   = wr & (avs_address == `OCC_OFF_CTRL);

    ////////////////////////////////////////////////////////////////////////////
    always @* begin
        nxt_ctrl      = ctrl_ff;
        nxt_primary   = primary_ff;
        nxt_secondary = secondary_ff;
        nxt_mask      = mask_ff;
        nxt_out       = compare_output_pin;
        nxt_fault     = fault_ff;
        nxt_done      = done_ff;
        nxt_rdata     = 32'h00000000;
        ev            = 2'h0;
        if (wr) begin
            case (avs_address)
                `OCC_OFF_CTRL: begin
                    // Fault bit and unimplemented bits are not writable
                    nxt_ctrl = (ctrl_ff & ~(bmask & `OCC_CTRL_WMASK))
                             | (wdata & bmask & `OCC_CTRL_WMASK);
                end
                `OCC_OFF_PRIMARY: begin
                    nxt_primary = (primary_ff & ~bmask) | (wdata & bmask);
                end
                `OCC_OFF_SECONDARY: begin
                    nxt_secondary = (secondary_ff & ~bmask) | (wdata & bmask);
                end
                `OCC_OFF_MASK: begin
                    if (avs_byteenable[0]) begin
                        nxt_mask = wdata[`OCC_IRQ_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // Mode change re-initialises the pin on the next cycle
        if (mode_wr_ff) begin
            nxt_done  = 1'b0;
            nxt_fault = 1'b0;
            case (mode)
                `OCC_MODE_FALL: nxt_out = 1'b1;
                `OCC_MODE_TOGGLE: nxt_out = compare_output_pin;
                default: nxt_out = 1'b0;
            endcase
        end else if (run) begin
            case (mode)
                `OCC_MODE_RISE: begin
                    if (match_a) nxt_out = 1'b1;
                end
                `OCC_MODE_FALL: begin
                    if (match_a) nxt_out = 1'b0;
                end
                `OCC_MODE_TOGGLE: begin
                    if (match_a) nxt_out = ~compare_output_pin;
                end
                `OCC_MODE_SINGLE: begin
                    if (match_a & ~done_ff) nxt_out = 1'b1;
                    if (match_b & compare_output_pin) begin
                        nxt_out  = 1'b0;
                        nxt_done = 1'b1;
                    end
                end
                `OCC_MODE_CONT: begin
                    if (match_a) nxt_out = 1'b1;
                    if (match_b) nxt_out = 1'b0;
                end
                `OCC_MODE_PWM, `OCC_MODE_PWMF: begin
                    if (period_st) nxt_out = 1'b1;
                    if (match_a) nxt_out = 1'b0;
                end
                default: begin
                end
            endcase
            // Fault input acted on only in the faulted PWM mode
            if ((mode == `OCC_MODE_PWMF) & fsync2_ff) begin
                nxt_fault = 1'b1;
            end
            if (nxt_fault) nxt_out = 1'b0;
            ev[`OCC_IRQ_MATCH] = match_a;
        end
        // Flag cleared outside the faulted PWM mode, new mode included
        if (nxt_ctrl[`OCC_MODE_HI:0] != `OCC_MODE_PWMF) nxt_fault = 1'b0;
        ev[`OCC_IRQ_FAULT] = nxt_fault & ~fault_ff;
        nxt_ctrl[`OCC_BIT_FAULT] = nxt_fault;
        // Set wins over write-one-to-clear
        nxt_status = status_ff | ev;
        if (wr & (avs_address == `OCC_OFF_STATUS) & avs_byteenable[0]) begin
            nxt_status = (status_ff & ~wdata[`OCC_IRQ_W-1:0]) | ev;
        end
        // Loaded with the ack so data stand while waitrequest is low
        if (access & avs_read) begin
            case (avs_address)
                `OCC_OFF_CTRL: nxt_rdata = {16'h0000, ctrl_ff};
                `OCC_OFF_PRIMARY: nxt_rdata = {16'h0000, primary_ff};
                `OCC_OFF_SECONDARY: nxt_rdata = {16'h0000, secondary_ff};
                `OCC_OFF_STATUS: nxt_rdata = {30'h00000000, status_ff};
                `OCC_OFF_MASK: nxt_rdata = {30'h00000000, mask_ff};
                default: nxt_rdata = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault and idle come from outside: two flops before use
    always @(posedge sys_clk) begin
        if (!rstn) begin
            ctrl_ff            <= `OCC_CTRL_RESET;
            primary_ff         <= 16'h0000;
            secondary_ff       <= 16'h0000;
            status_ff          <= 2'h0;
            mask_ff            <= 2'h0;
            fault_ff           <= 1'b0;
            done_ff            <= 1'b0;
            fsync1_ff          <= 1'b0;
            fsync2_ff          <= 1'b0;
            isync1_ff          <= 1'b0;
            isync2_ff          <= 1'b0;
            ack_ff             <= 1'b0;
            mode_wr_ff         <= 1'b0;
            compare_output_pin <= 1'b0;
            irq                <= 1'b0;
            avs_readdata       <= 32'h00000000;
            avs_waitrequest    <= 1'b1;
        end else begin
            ctrl_ff            <= nxt_ctrl;
            primary_ff         <= nxt_primary;
            secondary_ff       <= nxt_secondary;
            status_ff          <= nxt_status;
            mask_ff            <= nxt_mask;
            fault_ff           <= nxt_fault;
            done_ff            <= nxt_done;
            fsync1_ff          <= pwm_fault_in;
            fsync2_ff          <= fsync1_ff;
            isync1_ff          <= cpu_idle;
            isync2_ff          <= isync1_ff;
            ack_ff             <= access;
            mode_wr_ff         <= ctrl_wr & avs_byteenable[0];
            compare_output_pin <= nxt_out;
            irq                <= |(nxt_status & nxt_mask);
            avs_readdata       <= nxt_rdata;
            avs_waitrequest    <= ~access;
        end
    end

endmodule // occ_channel

/* File: tb/occ_properties.sv */
// Port checker for the output compare channel
`timescale 1ns/10ps
module occ_properties (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic [2:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        pwm_fault_in,
    input wire logic        compare_output_pin,
    input wire logic        irq
);
    logic [2:0] mode_ff;
    logic [1:0] mask_ff;
    wire        req  = avs_read | avs_write;
    wire        take = avs_write & ~avs_waitrequest & avs_byteenable[0];
    wire        rd   = avs_read & ~avs_waitrequest;
    // Shadow of mode and mask, since the checker cannot see the registers
    always @(posedge sys_clk) begin
        if (!rstn) begin
            mode_ff <= 3'h0;
            mask_ff <= 2'h0;
        end else if (take && avs_address == 3'h0) begin
            mode_ff <= avs_writedata[2:0];
        end else if (take && avs_address == 3'h4) begin
            mask_ff <= avs_writedata[1:0];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_answer;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    a_wait_fixed: assert property (req && !$past(req) |-> s_answer) else $error("late answer");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long ack");
    a_rdata_idle: assert property (avs_waitrequest |-> avs_readdata == 32'h0) else $error("rdata");
    a_read_unmapped: assert property (rd && avs_address > 3'h4 |-> avs_readdata == 32'h0)
        else $error("unmapped read");
    a_ctrl_unimpl: assert property (rd && avs_address == 3'h0 |->
        (avs_readdata & 32'hffffdfe0) == 32'h0) else $error("unimplemented bits");
    a_flag_mode: assert property (rd && avs_address == 3'h0 && mode_ff != 3'h7
        |-> !avs_readdata[4]) else $error("fault flag outside mode");
    a_fault_force: assert property ((mode_ff == 3'h7 && pwm_fault_in) [*5]
        |-> !compare_output_pin) else $error("pin not forced low");
    a_off_quiet: assert property (mode_ff == 3'h0 [*4] |-> !compare_output_pin)
        else $error("pin active while off");
    a_irq_masked: assert property (mask_ff == 2'h0 [*3] |-> !irq) else $error("irq unmasked");
    a_rst_quiet: assert property (disable iff (1'b0) !rstn |=> avs_waitrequest && !irq
        && !compare_output_pin && avs_readdata == 32'h0) else $error("reset state");
endmodule // occ_properties
bind occ_channel occ_properties chk (
    .sys_clk            (sys_clk),
    .rstn               (rstn),
    .avs_address        (avs_address),
    .avs_read           (avs_read),
    .avs_write          (avs_write),
    .avs_writedata      (avs_writedata),
    .avs_byteenable     (avs_byteenable),
    .avs_readdata       (avs_readdata),
    .avs_waitrequest    (avs_waitrequest),
    .pwm_fault_in       (pwm_fault_in),
    .compare_output_pin (compare_output_pin),
    .irq                (irq)
);

/* File: tb/occ_pin_load.sv */
// Load on the compare pin that counts pulses and high cycles
`timescale 1ns/10ps
module occ_pin_load (
    input wire logic        sys_clk,
    input wire logic        pin,
    input wire logic        clr,
    output logic     [7:0]  rises,
    output logic     [8:0]  highs
);
    logic last_ff;
    always @(posedge sys_clk) begin
        last_ff <= pin;
        if (clr) begin
            rises <= 8'h00;
            highs <= 9'h000;
        end else begin
            rises <= rises + {7'h00, pin & ~last_ff};
            highs <= highs + {8'h00, pin};
        end
    end
endmodule // occ_pin_load

/* File: tb/occ_channel_bench.sv */
// Self-checking bench for the output compare channel
`timescale 1ns/10ps
module occ_channel_bench;
    logic        sys_clk, rstn, avs_read, avs_write, cpu_idle, pwm_fault_in, t2_run, clr;
    logic [2:0]  avs_address;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic        avs_waitrequest, compare_output_pin, irq;
    logic [15:0] first_time_base, second_time_base;
    logic [7:0]  rises;
    logic [8:0]  highs;
    integer      failures, checks_done, m;
    occ_channel dut (
        .sys_clk            (sys_clk),
        .rstn               (rstn),
        .avs_address        (avs_address),
        .avs_read           (avs_read),
        .avs_write          (avs_write),
        .avs_writedata      (avs_writedata),
        .avs_byteenable     (avs_byteenable),
        .avs_readdata       (avs_readdata),
        .avs_waitrequest    (avs_waitrequest),
        .first_time_base    (first_time_base),
        .second_time_base   (second_time_base),
        .cpu_idle           (cpu_idle),
        .pwm_fault_in       (pwm_fault_in),
        .compare_output_pin (compare_output_pin),
        .irq                (irq)
    );
    occ_pin_load load (.sys_clk(sys_clk), .pin(compare_output_pin), .clr(clr), .rises(rises),
        .highs(highs));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Short timer period of 64 keeps every window small
    always @(posedge sys_clk) begin
        first_time_base <= {10'h000, first_time_base[5:0] + 6'h01};
        if (t2_run) second_time_base <= {10'h000, second_time_base[5:0] + 6'h01};
    end
    task chk(input logic ok);
        begin
            checks_done = checks_done + 1;
            if (!ok) begin
                failures = failures + 1;
                $display("ERROR %0t mismatch", $time);
            end
        end
    endtask
    task cyc(input integer c);
        repeat (c) @(posedge sys_clk);
    endtask
    task bus(input logic w, input logic [2:0] a, input logic [15:0] d);
        integer n;
        begin
            @(posedge sys_clk);
            avs_write <= w;
            avs_read <= ~w;
            avs_address <= a;
            avs_writedata <= {16'h0000, d};
            n = 0;
            @(posedge sys_clk);
            while (avs_waitrequest !== 1'b0 && n < 20) begin
                n = n + 1;
                @(posedge sys_clk);
            end
            if (n == 20) begin
                failures = failures + 1;
                $display("ERROR %0t bus timeout", $time);
            end
            q = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask
    // Start every mode write at count 40, far from any match
    task run(input logic [15:0] c, input logic [7:0] r, input logic [8:0] h);
        begin
            while (first_time_base !== 16'h0028) @(negedge sys_clk);
            // Leave the negedge so every stimulus change follows a rising edge
            if (c != 16'hffff) bus(1'b1, 3'h0, c);
            else @(posedge sys_clk);
            clr <= 1'b1;
            @(posedge sys_clk);
            clr <= 1'b0;
            cyc(192);
            chk(rises === r && highs === h);
        end
    endtask
    task t_edges;
        begin
            bus(1'b1, 3'h1, 16'h0014);
            for (m = 1; m <= 3; m++) begin
                run(16'hffff, 8'h00, (m == 2) ? 9'h0bf : 9'h000);
                bus(1'b1, 3'h0, {13'h0000, m[2:0]});
                cyc(3);
                chk(compare_output_pin === (m == 2));
                cyc(64);
                chk(compare_output_pin === (m != 2));
            end
            bus(1'b1, 3'h0, 16'h0009);
            cyc(70);
            chk(compare_output_pin === 1'b0);
            t2_run <= 1'b1;
            cyc(70);
            chk(compare_output_pin === 1'b1);
            $display("edges done");
        end
    endtask
    task t_pulses;
        begin
            bus(1'b0, 3'h5, 16'h0000);
            chk(q === 32'h0);
            bus(1'b1, 3'h1, 16'h000a);
            bus(1'b1, 3'h2, 16'h001e);
            cpu_idle <= 1'b1;
            run(16'h0000, 8'h00, 9'h000);
            run(16'h0004, 8'h01, 9'h014);
            run(16'h2005, 8'h00, 9'h000);
            run(16'h0005, 8'h03, 9'h03c);
            bus(1'b1, 3'h0, 16'hfff0);
            bus(1'b0, 3'h0, 16'h0000);
            chk(q === 32'h2000);
            $display("pulses done");
        end
    endtask
    task t_fault;
        begin
            bus(1'b1, 3'h1, 16'h0010);
            pwm_fault_in <= 1'b1;
            run(16'h0006, 8'h03, 9'h030);
            bus(1'b0, 3'h0, 16'h0000);
            chk(q === 32'h0006);
            run(16'h0007, 8'h00, 9'h000);
            bus(1'b0, 3'h0, 16'h0000);
            chk(q === 32'h0017 && irq === 1'b0);
            bus(1'b1, 3'h4, 16'h0002);
            pwm_fault_in <= 1'b0;
            cyc(2);
            chk(irq === 1'b1);
            run(16'hffff, 8'h00, 9'h000);
            bus(1'b1, 3'h3, 16'h0002);
            cyc(2);
            chk(irq === 1'b0);
            run(16'h0007, 8'h03, 9'h030);
            bus(1'b0, 3'h0, 16'h0000);
            chk(q === 32'h0007);
            $display("fault done");
        end
    endtask
    task conclude;
        begin
            $display("checks %0d failures %0d", checks_done, failures);
            if (failures == 0 && checks_done > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        {rstn, avs_read, avs_write, cpu_idle, pwm_fault_in, t2_run, clr} = 7'h00;
        avs_address = 3'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        first_time_base = 16'h0000;
        second_time_base = 16'h0000;
        failures = 0;
        checks_done = 0;
        cyc(10);
        rstn <= 1'b1;
        t_edges;
        t_pulses;
        t_fault;
        conclude;
    end
    initial begin
        #500000;
        failures = failures + 1;
        conclude;
    end
endmodule // occ_channel_bench
